// file: core/pin_sync.sv
// two-flop synchroniser for pins from another clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : pin_sync

// file: core/sflash_device.sv
// serial flash device end: auto-increment program, sleep, ids, otp
//
// Behaviour
// - auto-increment program needs write latch set
// - two bytes msb first, even then odd
// - one byte aborts; extra bytes are dropped
// - protected target ignores command, latch unchanged
// - no wrap; past last address leave mode
// - auto-increment mode accepts only four commands
// - latch clear in mode only when idle
// - host sends address once, ends, confirms
// - host waits for idle before next command
// - ready flag driven on select in mode when enabled
// - ready output commands refused inside mode
// - deep sleep after delay ignores most commands
// - wake needs deselect right after eight bits
// - wake from sleep takes wake delay
// - signature repeats; needs one full readout
// - no wake or signature while busy
// - id command: opcode, two dummies, address, codes
// - address 01h swaps order; codes alternate
// - otp enter/exit switch read/program target
// - otp access refuses security write; lock freezes otp
// - security byte readable any time but in sleep, repeated
// - security byte bit layout
// - security write needs no latch, sets lock
`timescale 1ns/1ps
module sflash_device import sflash_pkg::*; #(
  parameter int         ADDR_W           = 12,
  parameter int         PROT_BASE        = 3584,
  parameter int         BYTE_PROG_CYCLES = BYTE_PROG_CYC,
  parameter logic       FACTORY_LOCKED   = 1'b0
) (
  input  wire logic     clk_i,
  input  wire logic     reset_n_i,
  sflash_link_if.device link,
  output logic          busy_o,
  output logic          sleep_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic        cs_q;
    logic        sck_q;
    logic [7:0]  sr;
    logic [2:0]  bitp;
    logic [3:0]  nb;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  osr;
    logic        out_act;
    logic        alt;
    logic        so;
    logic        write_latch_bit;
    logic        busy;
    logic        ai;
    logic        ai_end;
    logic        ry_en;
    logic        sleep;
    logic        slp_pend;
    logic        wake_pend;
    logic        otp_sel;
    logic        lock;
    logic [15:0] tmr;
  } dev_state_t;

  dev_state_t       s;
  dev_state_t       next_s;
  logic [2:0]       pins;
  logic [7:0]       mem [2**ADDR_W];
  logic [7:0]       otp [OTP_BYTES];
  logic             mem_we;
  logic             otp_we;
  logic [23:0]      base;
  logic [7:0]       rx;
  logic [7:0]       op_now;
  logic [7:0]       stat;
  logic [7:0]       sec;
  logic [3:0]       hdr;
  logic             rise;
  logic             fall;
  logic             cs_rise;
  logic             prot;

  pin_sync #(.WIDTH(3), .RESET_VAL(3'b101)) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({link.cs_n, link.sck, link.mosi}),
    .q_o       (pins)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_s  = s;
    mem_we  = 1'b0;
    otp_we  = 1'b0;
    rise    = !s.sck_q && pins[1] && !pins[2];
    fall    = s.sck_q && !pins[1] && !pins[2];
    cs_rise = !s.cs_q && pins[2];
    rx      = {s.sr[6:0], pins[0]};
    op_now  = (s.nb == 4'd0) ? rx : s.op;
    hdr     = s.ai ? 4'd1 : 4'd4;
    stat    = 8'h00;
    stat[STAT_BUSY_BIT]  = s.busy;
    stat[STAT_LATCH_BIT] = s.write_latch_bit;
    sec     = 8'h00;
    sec[SEC_AUTO_INC_BIT] = s.ai;
    sec[SEC_LOCK_BIT]     = s.lock;
    sec[SEC_FACTORY_BIT]  = FACTORY_LOCKED;
    base    = s.ai ? s.addr : {s.addr[23:1], 1'b0};
    prot    = s.otp_sel ? (s.lock || base >= 24'(OTP_BYTES))
                        : (base >= 24'(PROT_BASE));
    next_s.cs_q  = pins[2];
    next_s.sck_q = pins[1];

    // self-timed cycles share one down-counter; a program cycle started during the sleep entry delay restarts it
    if (s.tmr != 16'h0000) begin
      next_s.tmr = s.tmr - 16'h0001;
    end else begin
      if (s.busy) begin
        next_s.busy = 1'b0;
        if (s.ai_end) begin
          next_s.ai     = 1'b0;
          next_s.write_latch_bit    = 1'b0;
          next_s.ai_end = 1'b0;
        end
      end
      if (s.slp_pend) begin
        next_s.slp_pend = 1'b0;
        next_s.sleep    = 1'b1;
      end
      if (s.wake_pend) begin
        next_s.wake_pend = 1'b0;
        next_s.sleep     = 1'b0;
      end
    end

    if (pins[2]) begin
      next_s.bitp    = 3'd0;
      next_s.nb      = 4'd0;
      next_s.out_act = 1'b0;
      next_s.alt     = 1'b0;
    end

    // ========================================================
    // shift in on rising clock, load answer at byte end
    if (rise) begin
      next_s.sr   = rx;
      next_s.bitp = s.bitp + 3'd1;
      if (s.bitp == 3'd7) begin
        if (s.nb != 4'hF) begin
          next_s.nb = s.nb + 4'd1;
        end
        if (s.nb == 4'd0) begin
          next_s.op = rx;
        end else if (s.nb < 4'd4 && !s.ai) begin
          next_s.addr = {s.addr[15:0], rx};
        end
        if (s.nb == hdr) begin
          next_s.d0 = rx;
        end
        if (s.nb == hdr + 4'd1) begin
          next_s.d1 = rx;
        end
        if (!s.sleep || op_now == CMD_LEGACY_SIG) begin
          if (op_now == CMD_READ_STATUS) begin
            next_s.osr     = stat;
            next_s.out_act = 1'b1;
          end else if (op_now == CMD_READ_SECURITY) begin
            next_s.osr     = sec;
            next_s.out_act = 1'b1;
          end else if (s.ai) begin
            next_s.out_act = s.out_act;
          end else if (op_now == CMD_LEGACY_SIG && !s.busy) begin
            next_s.osr     = PART_CODE;
            next_s.out_act = 1'b1;
          end else if ((op_now == CMD_MAKER_PART_ID ||
                        op_now == CMD_MAKER_PART_ID_A ||
                        op_now == CMD_MAKER_PART_ID_B) &&
                       s.nb >= 4'd3) begin
            next_s.osr = (((s.nb == 4'd3) ? rx : s.addr[7:0]) ==
                          ID_SWAP_ADDR) ^ s.alt ?
                         PART_CODE : MAKER_CODE;
            next_s.alt     = !s.alt;
            next_s.out_act = 1'b1;
          end else if (op_now == CMD_READ && s.nb >= 4'd3) begin
            next_s.osr = s.otp_sel ?
                         otp[next_s.addr[OTP_AW-1:0]] :
                         mem[next_s.addr[ADDR_W-1:0]];
            next_s.addr    = next_s.addr + 24'd1;
            next_s.out_act = 1'b1;
          end
        end
      end
    end

    // answer bits change on the falling clock, msb first
    if (fall) begin
      next_s.so  = s.osr[7];
      next_s.osr = {s.osr[6:0], 1'b0};
    end

    // ========================================================
    // commands act when select rises on a byte boundary
    if (cs_rise && s.bitp == 3'd0 && s.nb != 4'd0) begin
      unique case (s.op)
        CMD_WRITE_LATCH_SET: begin
          if (!s.sleep && !s.ai && !s.busy) next_s.write_latch_bit = 1'b1;
        end
        CMD_WRITE_LATCH_CLEAR: begin
          if (!s.sleep && !s.busy) begin
            next_s.write_latch_bit = 1'b0;
            next_s.ai  = 1'b0;
          end
        end
        CMD_AUTO_INC: begin
          if (!s.sleep && s.write_latch_bit && !s.busy && !prot &&
              s.nb >= hdr + 4'd2) begin
            mem_we        = !s.otp_sel;
            otp_we        = s.otp_sel;
            next_s.addr   = base + 24'd2;
            next_s.ai     = 1'b1;
            next_s.busy   = 1'b1;
            next_s.tmr    = 16'(BYTE_PROG_CYCLES - 1);
            next_s.ai_end = s.otp_sel ?
              (base + 24'd2 >= 24'(OTP_BYTES)) :
              (base + 24'd2 >= 24'(PROT_BASE));
          end
        end
        CMD_READY_ON: begin
          if (!s.sleep && !s.ai) next_s.ry_en = 1'b1;
        end
        CMD_READY_OFF: begin
          if (!s.sleep && !s.ai) next_s.ry_en = 1'b0;
        end
        CMD_DEEP_SLEEP: begin
          if (!s.sleep && !s.ai && !s.busy) begin
            next_s.slp_pend = 1'b1;
            next_s.tmr      = 16'(SLEEP_CYC - 1);
          end
        end
        CMD_WAKE, CMD_LEGACY_SIG: begin
          if (!s.busy && ((s.op == CMD_WAKE && s.nb == 4'd1) ||
                          (s.op == CMD_LEGACY_SIG && s.nb >= 4'd2))) begin
            next_s.slp_pend = 1'b0;
            if (s.sleep && !s.wake_pend) begin
              next_s.wake_pend = 1'b1;
              next_s.tmr       = 16'(WAKE_CYC - 1);
            end
          end
        end
        CMD_OTP_ENTER: begin
          if (!s.sleep && !s.ai) next_s.otp_sel = 1'b1;
        end
        CMD_OTP_EXIT: begin
          if (!s.sleep && !s.ai) next_s.otp_sel = 1'b0;
        end
        CMD_SECURITY_WRITE: begin
          if (!s.sleep && !s.ai && !s.busy && !s.otp_sel) begin
            next_s.lock = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // registers and arrays
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s       <= '0;
      s.cs_q  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // arrays carry no reset; unprogrammed cells read unknown
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[base[ADDR_W-1:0]]            <= s.d0;
      mem[base[ADDR_W-1:0] | ADDR_W'(1)] <= s.d1;
    end
    if (otp_we) begin
      otp[base[OTP_AW-1:0]]            <= s.d0;
      otp[base[OTP_AW-1:0] | OTP_AW'(1)] <= s.d1;
    end
  end

  // ==========================================================
  // outputs
  assign link.so_oe = !s.cs_q && (s.out_act || (s.ry_en && s.ai));
  assign link.so_d  = s.out_act ? s.so : !s.busy;
  assign busy_o     = s.busy;
  assign sleep_o    = s.sleep;

endmodule : sflash_device

// file: core/sflash_host.sv
// host controller end: runs one framed flash command per software order
`timescale 1ns/1ps
module sflash_host import sflash_pkg::*; #(
  parameter int SCK_HALF   = SCK_HALF_CYC,
  parameter int GAP_CYCLES = CS_GAP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  sflash_link_if.host      link
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW  = 2'b01,
    H_HIGH = 2'b10,
    H_GAP  = 2'b11
  } host_phase_t;

  typedef struct packed {
    host_phase_t phase;
    logic [8:0]  cnt;
    logic [6:0]  bitn;
    logic [6:0]  total;
    logic [39:0] tx;
    logic [31:0] txw;
    logic [31:0] rxw;
    logic [31:0] rdata;
    logic        cs_n;
    logic        sck;
    logic        mosi;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic        so_s;
  logic [2:0]  txn;
  logic [2:0]  rxn;

  pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_so_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (link.so),
    .q_o       (so_s)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_s       = s;
    next_s.rdata = 32'h0000_0000;
    txn          = wdata_i[CTRL_TXN_LSB +: 3];
    rxn          = wdata_i[CTRL_RXN_LSB +: 3];
    if (rd_i) begin
      unique case (addr_i)
        HREG_TX:   next_s.rdata = s.txw;
        HREG_RX:   next_s.rdata = s.rxw;
        HREG_STAT: next_s.rdata = {31'h0000_0000, s.phase != H_IDLE};
        default:   next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_i && addr_i == HREG_TX) begin
      next_s.txw = wdata_i;
    end
    unique case (s.phase)
      H_IDLE: begin
        if (wr_i && addr_i == HREG_CTRL) begin
          // whole bytes only, so select rises on a boundary
          next_s.total = 7'({3'b000, txn} + {3'b000, rxn} + 6'd1) << 3;
          next_s.tx    = {wdata_i[7:0], s.txw};
          next_s.mosi  = wdata_i[7];
          next_s.cs_n  = 1'b0;
          next_s.bitn  = 7'd0;
          next_s.cnt   = 9'd0;
          next_s.phase = H_LOW;
        end
      end
      H_LOW: begin
        if (s.cnt == 9'(SCK_HALF - 1)) begin
          next_s.sck   = 1'b1;
          next_s.cnt   = 9'd0;
          next_s.phase = H_HIGH;
        end else begin
          next_s.cnt = s.cnt + 9'd1;
        end
      end
      H_HIGH: begin
        if (s.cnt == 9'(SCK_HALF - 1)) begin
          // sampled late in the high half to cover both synchronisers
          next_s.rxw = {s.rxw[30:0], so_s};
          next_s.sck = 1'b0;
          next_s.cnt = 9'd0;
          if (s.bitn == s.total - 7'd1) begin
            next_s.cs_n  = 1'b1;
            next_s.phase = H_GAP;
          end else begin
            next_s.bitn  = s.bitn + 7'd1;
            next_s.tx    = {s.tx[38:0], 1'b0};
            next_s.mosi  = s.tx[38];
            next_s.phase = H_LOW;
          end
        end else begin
          next_s.cnt = s.cnt + 9'd1;
        end
      end
      H_GAP: begin
        // deselect covers the longest wake delay after every frame
        if (s.cnt == 9'(GAP_CYCLES - 1)) begin
          next_s.phase = H_IDLE;
        end else begin
          next_s.cnt = s.cnt + 9'd1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s      <= '0;
      s.cs_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign link.cs_n = s.cs_n;
  assign link.sck  = s.sck;
  assign link.mosi = s.mosi;
  assign rdata_o   = s.rdata;

endmodule : sflash_host

// file: core/sflash_link_if.sv
// serial link between host controller and flash device
`timescale 1ns/1ps
interface sflash_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic so_d;
  logic so_oe;
  wire  so;

  // a released line shows the inverse of its last value, so a host that
  // samples it while nobody drives cannot read the expected bits by luck
  assign so = so_oe ? so_d : !so_d;

  modport device (input cs_n, input sck, input mosi,
                  output so_d, output so_oe);
  modport host   (output cs_n, output sck, output mosi, input so);
endinterface : sflash_link_if

// file: core/sflash_pkg.sv
// shared constants for the serial flash device and its host controller
package sflash_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS         = 40;
  localparam int BYTE_PROG_NS   = 300000;
  localparam int SLEEP_ENTRY_NS = 10000;
  localparam int WAKE_DELAY_NS  = 8800;
  // device delays are longest times: round down
  localparam int BYTE_PROG_CYC  = BYTE_PROG_NS / CLK_NS;
  localparam int SLEEP_CYC      = SLEEP_ENTRY_NS / CLK_NS;
  localparam int WAKE_CYC       = WAKE_DELAY_NS / CLK_NS;
  // host deselect is a least time: round up
  localparam int CS_GAP_CYC     = (WAKE_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_CYC   = 4;

  // ==========================================================
  // opcodes
  localparam logic [7:0] CMD_WRITE_LATCH_SET   = 8'h06;
  localparam logic [7:0] CMD_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS       = 8'h05;
  localparam logic [7:0] CMD_READ_SECURITY     = 8'h2B;
  localparam logic [7:0] CMD_AUTO_INC          = 8'hAD;
  localparam logic [7:0] CMD_READ              = 8'h03;
  localparam logic [7:0] CMD_MAKER_PART_ID     = 8'h90;
  localparam logic [7:0] CMD_MAKER_PART_ID_A   = 8'hEF;
  localparam logic [7:0] CMD_MAKER_PART_ID_B   = 8'hDF;
  localparam logic [7:0] CMD_READY_ON          = 8'h70;
  localparam logic [7:0] CMD_READY_OFF         = 8'h80;
  localparam logic [7:0] CMD_DEEP_SLEEP        = 8'hB9;
  localparam logic [7:0] CMD_WAKE              = 8'hAB;
  localparam logic [7:0] CMD_LEGACY_SIG        = 8'hAC;
  localparam logic [7:0] CMD_OTP_ENTER         = 8'hB1;
  localparam logic [7:0] CMD_OTP_EXIT          = 8'hC1;
  localparam logic [7:0] CMD_SECURITY_WRITE    = 8'h2F;
  localparam logic [7:0] CMD_STATUS_WRITE      = 8'h01;

  // ==========================================================
  // register fields and identity
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_LATCH_BIT   = 1;
  localparam int SEC_FACTORY_BIT  = 0;
  localparam int SEC_LOCK_BIT     = 1;
  localparam int SEC_AUTO_INC_BIT = 4;
  localparam logic [7:0] ID_SWAP_ADDR = 8'h01;
  // identity values are arbitrary
  localparam logic [7:0] MAKER_CODE = 8'h5A;
  localparam logic [7:0] PART_CODE  = 8'h3C;
  localparam int OTP_BYTES = 64;
  localparam int OTP_AW    = 6;

  // ==========================================================
  // host register map and control fields
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_TX   = 4'h4;
  localparam logic [3:0] HREG_RX   = 4'h8;
  localparam logic [3:0] HREG_STAT = 4'hC;
  localparam int CTRL_TXN_LSB = 8;
  localparam int CTRL_RXN_LSB = 12;

endpackage : sflash_pkg

// file: testbench/sflash_properties.sv
// assertions on the link between the flash host and the flash device
`timescale 1ns/1ps
module sflash_properties import sflash_pkg::*; #(
  parameter int PROG = 600,
  parameter int GAP  = CS_GAP_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so_oe,
  input wire logic busy_o,
  input wire logic sleep_o
);
  // ==========================================================
  // link monitor
  // device delays start from its synchronised view: a few clocks slack
  localparam int PLO = PROG - 2;
  localparam int PHI = PROG + 2;
  localparam int SLO = SLEEP_CYC - 4;
  localparam int WLO = WAKE_CYC - 4;
  typedef struct packed {
    logic [8:0]  gap;
    logic [7:0]  bits;
    logic [10:0] blen;
    logic        sck_q;
  } mon_t;
  mon_t mon;
  mon_t next_mon;

  always_comb begin
    next_mon       = mon;
    next_mon.sck_q = sck;
    next_mon.gap   = !cs_n ? 9'h0 : mon.gap + {8'h0, ~&mon.gap};
    next_mon.bits  = cs_n ? 8'h0 : mon.bits + {7'h0, sck & ~mon.sck_q};
    next_mon.blen  = busy_o ? mon.blen + 11'h1 : 11'h0;
  end

  // idle since reset counts as a long deselect
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mon <= '{gap: 9'h1FF, default: '0};
    end else begin
      mon <= next_mon;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_so_release;
    cs_n [*6] |-> !so_oe;
  endproperty
  a_so_release: assert property (p_so_release)
    else $error("serial output driven while deselected");

  property p_frame_bytes;
    $rose(cs_n) |-> mon.bits[2:0] == 3'h0 && mon.bits != 8'h0;
  endproperty
  a_frame_bytes: assert property (p_frame_bytes)
    else $error("frame not closed on a byte boundary");

  property p_cs_gap;
    $fell(cs_n) |-> mon.gap >= 9'(GAP);
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("deselect gap too short");

  property p_sleep_entry;
    $rose(sleep_o) |-> cs_n && mon.gap >= 9'(SLO);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entered too early");

  property p_wake;
    $fell(sleep_o) |-> mon.gap >= 9'(WLO);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake finished before the wake delay");

  property p_sleep_quiet;
    sleep_o && !cs_n && mon.bits < 8'h08 |-> !so_oe;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("output driven in sleep before an answer");

  property p_busy_start;
    $rose(busy_o) |-> cs_n && mon.gap <= 9'h008;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("program cycle not started by frame end");

  property p_busy_len;
    $fell(busy_o) |-> mon.blen >= 11'(PLO) && mon.blen <= 11'(PHI);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("program cycle length wrong");

endmodule : sflash_properties

// file: testbench/test_serial_flash_autoinc_sleep_otp.sv
// self-checking bench: host controller and flash device on one link
`timescale 1ns/1ps
module test_serial_flash_autoinc_sleep_otp import sflash_pkg::*;;
  // ==========================================================
  // signals and instances
  localparam int PROG  = 600;
  localparam int LIMIT = 60000;
  logic        clk_i;
  logic        reset_n_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        busy_o;
  logic        sleep_o;
  logic [7:0]  id_op [3];
  int          mismatches;
  int          n_checks;
  int          cyc = 0;

  sflash_link_if link ();
  sflash_host u_sflash_host (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .link(link));
  // program cycle cut to 600 clocks, still long enough that commands can land while it runs
  sflash_device #(.BYTE_PROG_CYCLES(PROG)) u_sflash_device (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .link(link),
    .busy_o(busy_o), .sleep_o(sleep_o));
  sflash_properties #(.PROG(PROG)) u_sflash_properties (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n(link.cs_n),
    .sck(link.sck), .so_oe(link.so_oe), .busy_o(busy_o),
    .sleep_o(sleep_o));

  // ==========================================================
  // tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 q = rdata_o;
    @(posedge clk_i);
  endtask : acc

  // one framed command; waits for the host to finish the frame
  task automatic run(input logic [7:0] op, input int tn, input int rn,
                     input logic [31:0] tx, output logic [31:0] rx);
    logic [31:0] s;
    int          n;
    acc(1'b1, HREG_TX, tx, s);
    acc(1'b1, HREG_CTRL, 32'(op) | (32'(tn) << CTRL_TXN_LSB)
        | (32'(rn) << CTRL_RXN_LSB), s);
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 2000) begin
      acc(1'b0, HREG_STAT, 32'h0, s);
      n++;
    end
    if (n == 2000) mismatches++;
    acc(1'b0, HREG_RX, 32'h0, rx);
  endtask : run

  task automatic cmd(input logic [7:0] op, input int tn,
                     input logic [31:0] tx);
    logic [31:0] r;
    run(op, tn, 0, tx, r);
  endtask : cmd

  task automatic exp_rx(input logic [7:0] op, input int tn, input int rn,
                        input logic [31:0] tx, input logic [31:0] exp);
    logic [31:0] r;
    logic [31:0] mask;
    mask = (rn == 4) ? 32'hFFFF_FFFF : ((32'h1 << (8 * rn)) - 32'h1);
    run(op, tn, rn, tx, r);
    chk(r & mask, exp);
  endtask : exp_rx

  task automatic st(input logic [7:0] v);
    exp_rx(CMD_READ_STATUS, 0, 1, 32'h0, {24'h0, v});
  endtask : st

  task automatic sc(input logic [7:0] v);
    exp_rx(CMD_READ_SECURITY, 0, 1, 32'h0, {24'h0, v});
  endtask : sc

  // polls the status byte until the program cycle is over
  task automatic idle;
    logic [31:0] r;
    int          n;
    n = 0;
    r = 32'h1;
    while (r[STAT_BUSY_BIT] !== 1'b0 && n < 50) begin
      run(CMD_READ_STATUS, 0, 1, 32'h0, r);
      n++;
    end
    if (n == 50) mismatches++;
  endtask : idle

  task automatic sleep_is(input logic v);
    #1 chk(32'(sleep_o), {31'h0, v});
  endtask : sleep_is

  // ==========================================================
  // clock, timeout and test sequence
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    reset_n_i  = 1'b0;
    addr_i     = 4'h0;
    wdata_i    = 32'h0;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    mismatches = 0;
    n_checks   = 0;
    id_op = '{CMD_MAKER_PART_ID, CMD_MAKER_PART_ID_A, CMD_MAKER_PART_ID_B};
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sc(8'h00);
    cmd(CMD_AUTO_INC, 5, 32'h0002_00AB);
    st(8'h00);
    sc(8'h00);
    cmd(CMD_READY_ON, 0, 32'h0);
    cmd(CMD_WRITE_LATCH_SET, 0, 32'h0);
    st(8'h02);
    cmd(CMD_AUTO_INC, 5, 32'h0001_00AB);
    // in mode the output carries the ready flag: low while busy
    exp_rx(CMD_WRITE_LATCH_CLEAR, 0, 1, 32'h0, 32'h0);
    sc(8'h10);
    idle();
    // short frame is refused but the ready flag now reads high
    exp_rx(CMD_AUTO_INC, 0, 1, 32'h0, 32'h0000_00FF);
    cmd(CMD_READY_OFF, 0, 32'h0);
    cmd(CMD_DEEP_SLEEP, 0, 32'h0);
    cmd(CMD_WRITE_LATCH_SET, 0, 32'h0);
    st(8'h02);
    sleep_is(1'b0);
    cmd(CMD_AUTO_INC, 3, 32'h1234_EE00);
    exp_rx(CMD_WRITE_LATCH_CLEAR, 0, 1, 32'h0, 32'h0);
    idle();
    cmd(CMD_AUTO_INC, 1, 32'h5600_0000);
    st(8'h02);
    cmd(CMD_WRITE_LATCH_CLEAR, 0, 32'h0);
    st(8'h00);
    sc(8'h00);
    exp_rx(CMD_READ, 3, 4, 32'h0001_0000, 32'hAB00_1234);
    cmd(CMD_WRITE_LATCH_SET, 0, 32'h0);
    cmd(CMD_AUTO_INC, 5, 32'h000E_0077);
    st(8'h02);
    sc(8'h00);
    cmd(CMD_AUTO_INC, 5, 32'h000D_FE99);
    idle();
    st(8'h00);
    sc(8'h00);
    exp_rx(CMD_READ, 3, 2, 32'h000D_FE00, 32'h0000_9900);
    cmd(CMD_READY_OFF, 0, 32'h0);
    for (int i = 0; i < 6; i++) begin
      exp_rx(id_op[i % 3], 3, 4,
             {16'h0, (i < 3) ? 8'h00 : ID_SWAP_ADDR, 8'h0},
             (i < 3) ? {MAKER_CODE, PART_CODE, MAKER_CODE, PART_CODE}
                     : {PART_CODE, MAKER_CODE, PART_CODE, MAKER_CODE});
    end
    cmd(CMD_DEEP_SLEEP, 0, 32'h0);
    repeat (40) @(posedge clk_i);
    sleep_is(1'b1);
    cmd(CMD_WRITE_LATCH_SET, 0, 32'h0);
    exp_rx(CMD_LEGACY_SIG, 0, 2, 32'h0, {16'h0, PART_CODE, PART_CODE});
    repeat (8) @(posedge clk_i);
    sleep_is(1'b0);
    st(8'h00);
    cmd(CMD_DEEP_SLEEP, 0, 32'h0);
    repeat (40) @(posedge clk_i);
    cmd(CMD_WAKE, 1, 32'h0);
    sleep_is(1'b1);
    cmd(CMD_WAKE, 0, 32'h0);
    repeat (8) @(posedge clk_i);
    sleep_is(1'b0);
    cmd(CMD_OTP_ENTER, 0, 32'h0);
    cmd(CMD_WRITE_LATCH_SET, 0, 32'h0);
    cmd(CMD_AUTO_INC, 5, 32'h0000_00CD);
    idle();
    cmd(CMD_WRITE_LATCH_CLEAR, 0, 32'h0);
    exp_rx(CMD_READ, 3, 2, 32'h0, 32'h0000_CD00);
    cmd(CMD_SECURITY_WRITE, 0, 32'h0);
    sc(8'h00);
    cmd(CMD_OTP_EXIT, 0, 32'h0);
    cmd(CMD_SECURITY_WRITE, 0, 32'h0);
    sc(8'h02);
    cmd(CMD_OTP_ENTER, 0, 32'h0);
    cmd(CMD_WRITE_LATCH_SET, 0, 32'h0);
    cmd(CMD_AUTO_INC, 5, 32'h0000_0011);
    st(8'h02);
    exp_rx(CMD_READ, 3, 2, 32'h0, 32'h0000_CD00);
    cmd(CMD_OTP_EXIT, 0, 32'h0);
    give_verdict();
  end

endmodule : test_serial_flash_autoinc_sleep_otp
